// ---- rtl/cpu_exception_status.sv ----
// mode, status and cause state of the processor control unit
// assumes the pipeline reports at most one exception per cycle and is
// flushed by take_irq/exc_valid; all inputs are synchronous to clk
//
// Summary of operation
// - top four status bits enable coprocessors three to zero
// - coprocessor one clear traps its instructions always
// - coprocessor zero ops need kernel or usable bit
// - endian flip reverses byte order for user
// - boot vector bit selects rom or ram
// - multi-hit sets shutdown; only reset clears
// - translation-free build sets shutdown on first edge after reset
// - cache parity error sets flag, no trap
// - isolated load records would-have-hit result
// - parity-zero writes zero parity, skips check
// - isolate keeps accesses in data cache
// - swap exchanges instruction and data caches
// - eight-bit mask, six pins two software
// - no priority among interrupt sources
// - kernel bit; user limited to low half
// - enable bit zero blocks all interrupts
// - exception pushes privilege/enable stack
// - restore pops stack, no branch
// - unusable trap records coprocessor number
// - pending follows pins; two software bits stored
// - pending masked enabled bit raises interrupt
// - five-bit exception code in cause
// - return point is instruction or branch
`timescale 1ns/1ps
module cpu_exception_status
   import cpu_exc_pkg::*;
#(
   parameter bit HAS_TLB = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // external interrupt pins, level
   input wire logic [5:0] irq_pins,
   // control register access from the pipeline
   input creg_acc_t creg,
   output logic [31:0] creg_rdata,
   // exception report and restore instruction
   input exc_req_t exc,
   input wire logic restore_exc,
   // coprocessor instruction check and address check
   input cop_req_t cop,
   input wire logic [31:0] fetch_addr,
   input wire logic user_access_valid,
   // cache events
   input cache_evt_t cache_evt,
   // decisions back to the pipeline
   output logic cop_unusable,
   output logic [1:0] cop_unusable_unit,
   output logic addr_violation,
   output logic take_irq,
   // mode outputs
   output logic kernel_now,
   output logic user_endian_flip_eff,
   output logic boot_vector_select,
   output logic parity_zero_mode,
   output logic dcache_isolate,
   output logic cache_swap,
   output logic tlb_shutdown,
   output logic [31:0] return_point_reg
);

   // status storage
   logic [3:0] coproc_usable_q, coproc_usable_d;
   logic user_endian_flip_q, user_endian_flip_d;
   logic boot_vector_q, boot_vector_d;
   logic tlb_shutdown_q, tlb_shutdown_d;
   logic cache_parity_flag_q, cache_parity_flag_d;
   logic isolated_hit_flag_q, isolated_hit_flag_d;
   logic parity_zero_q, parity_zero_d;
   logic cache_swap_q, cache_swap_d;
   logic dcache_isolate_q, dcache_isolate_d;
   logic [7:0] irq_mask_q, irq_mask_d;
   // cause storage
   logic delay_slot_flag_q, delay_slot_flag_d;
   logic [1:0] coproc_err_q, coproc_err_d;
   logic [1:0] soft_irq_q, soft_irq_d;
   logic [4:0] exception_kind_q, exception_kind_d;
   logic [5:0] hw_pending_q;
   logic [31:0] return_point_q, return_point_d;
   // pipeline answers
   logic cop_unusable_q, cop_unusable_d;
   logic [1:0] cop_unit_q, cop_unit_d;
   logic addr_violation_q, addr_violation_d;
   logic take_irq_q, take_irq_d;
   logic [31:0] rdata_q, rdata_d;
   logic tlb_seen_q;
   logic flip_eff_q, flip_eff_d;
   logic kernel_next;
   // stack
   logic [5:0] stack_q;
   stack_op_t stack_op;
   logic [7:0] irq_pending;
   logic wr_status, wr_cause;
   logic [31:0] status_word, cause_word;

   assign wr_status = creg.wr && (creg.num == REG_MODE_STATUS);
   assign wr_cause = creg.wr && (creg.num == REG_CAUSE);
   assign irq_pending = {hw_pending_q, soft_irq_q};

   // privilege/enable stack: exception push beats restore and writes
   always_comb begin
      if (exc.valid) begin
         stack_op = STK_PUSH;
      end else if (restore_exc) begin
         stack_op = STK_POP;
      end else if (wr_status) begin
         stack_op = STK_WRITE;
      end else begin
         stack_op = STK_HOLD;
      end
   end

   mode_stack u_stack (
      .clk(clk),
      .reset(reset),
      .op(stack_op),
      .wr_data(creg.data[5:0]),
      .stack_q(stack_q)
   );

   // next privilege bit, same priority as the stack itself
   always_comb begin
      case (stack_op)
         STK_PUSH: kernel_next = 1'b1;
         STK_POP: kernel_next = stack_q[3];
         STK_WRITE: kernel_next = creg.data[1];
         default: kernel_next = stack_q[1];
      endcase
      // kernel code always keeps the byte order chosen at reset
      flip_eff_d = user_endian_flip_d && !kernel_next;
   end

   // readback images; reserved bits read zero
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_CU_HI:ST_CU_LO] = coproc_usable_q;
      status_word[ST_RE] = user_endian_flip_q;
      status_word[ST_BEV] = boot_vector_q;
      status_word[ST_TS] = tlb_shutdown_q;
      status_word[ST_PE] = cache_parity_flag_q;
      status_word[ST_CM] = isolated_hit_flag_q;
      status_word[ST_PZ] = parity_zero_q;
      status_word[ST_SWC] = cache_swap_q;
      status_word[ST_ISC] = dcache_isolate_q;
      status_word[ST_IM_HI:ST_IM_LO] = irq_mask_q;
      status_word[5:0] = stack_q;
      cause_word = 32'h0000_0000;
      cause_word[CA_BD] = delay_slot_flag_q;
      cause_word[CA_CE_HI:CA_CE_LO] = coproc_err_q;
      cause_word[CA_IP_HI:CA_IP_LO] = irq_pending;
      cause_word[CA_EXC_HI:CA_EXC_LO] = exception_kind_q;
   end

   // status register next values
   always_comb begin
      coproc_usable_d = coproc_usable_q;
      user_endian_flip_d = user_endian_flip_q;
      boot_vector_d = boot_vector_q;
      cache_parity_flag_d = cache_parity_flag_q;
      isolated_hit_flag_d = isolated_hit_flag_q;
      parity_zero_d = parity_zero_q;
      cache_swap_d = cache_swap_q;
      dcache_isolate_d = dcache_isolate_q;
      irq_mask_d = irq_mask_q;
      if (wr_status) begin
         coproc_usable_d = creg.data[ST_CU_HI:ST_CU_LO];
         user_endian_flip_d = creg.data[ST_RE];
         boot_vector_d = creg.data[ST_BEV];
         cache_parity_flag_d = creg.data[ST_PE];
         isolated_hit_flag_d = creg.data[ST_CM];
         parity_zero_d = creg.data[ST_PZ];
         cache_swap_d = creg.data[ST_SWC];
         dcache_isolate_d = creg.data[ST_ISC];
         irq_mask_d = creg.data[ST_IM_HI:ST_IM_LO];
      end
      // hardware events win over a software write in the same cycle
      if (cache_evt.parity_err && !parity_zero_q) begin
         cache_parity_flag_d = 1'b1;
      end
      if (cache_evt.isolated_load && dcache_isolate_q) begin
         isolated_hit_flag_d = cache_evt.isolated_hit;
      end
      // software cannot clear shutdown; only reset does
      tlb_shutdown_d = tlb_shutdown_q | (HAS_TLB & cache_evt.tlb_multi_hit);
   end

   // cause register, return point and pipeline answers
   always_comb begin
      delay_slot_flag_d = delay_slot_flag_q;
      coproc_err_d = coproc_err_q;
      soft_irq_d = soft_irq_q;
      exception_kind_d = exception_kind_q;
      return_point_d = return_point_q;
      if (wr_cause) begin
         soft_irq_d = creg.data[CA_SW_HI:CA_IP_LO];
      end
      if (exc.valid) begin
         exception_kind_d = exc.kind;
         delay_slot_flag_d = exc.in_delay_slot;
         // restart at the branch when the fault sits in its delay slot
         return_point_d = exc.in_delay_slot ? exc.pc - 32'h0000_0004 : exc.pc;
         if (exc.kind == EXC_COPROC_UNUSABLE) begin
            coproc_err_d = cop_unit_q;
         end
      end
      // coprocessor usability: unit 0 always usable in kernel
      cop_unusable_d = 1'b0;
      cop_unit_d = cop_unit_q;
      if (cop.valid) begin
         cop_unit_d = cop.unit;
         if (cop.unit == 2'd0) begin
            cop_unusable_d = !coproc_usable_q[0] && !stack_q[1];
         end else begin
            cop_unusable_d = !coproc_usable_q[cop.unit];
         end
      end
      // user mode restricted to the lower half of the address space
      addr_violation_d = user_access_valid && !stack_q[1] && (fetch_addr > USER_ADDR_MAX);
      // any unmasked pending source, no priority among them
      take_irq_d = stack_q[0] && |(irq_pending & irq_mask_q) && !exc.valid;
      rdata_d = 32'h0000_0000;
      case (creg.num)
         REG_MODE_STATUS: rdata_d = status_word;
         REG_CAUSE: rdata_d = cause_word;
         REG_RETURN_POINT: rdata_d = return_point_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // status flops; isolate is left as is by reset in real silicon, here
   // cleared so simulation has no unknowns; software must still set it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         coproc_usable_q <= CU_RESET;
         user_endian_flip_q <= 1'b0;
         boot_vector_q <= BEV_RESET;
         cache_parity_flag_q <= 1'b0;
         isolated_hit_flag_q <= 1'b0;
         parity_zero_q <= 1'b0;
         cache_swap_q <= 1'b0;
         dcache_isolate_q <= 1'b0;
         irq_mask_q <= IM_RESET;
         tlb_shutdown_q <= 1'b0;
         tlb_seen_q <= 1'b0;
         flip_eff_q <= 1'b0;
      end else begin
         coproc_usable_q <= coproc_usable_d;
         user_endian_flip_q <= user_endian_flip_d;
         boot_vector_q <= boot_vector_d;
         cache_parity_flag_q <= cache_parity_flag_d;
         isolated_hit_flag_q <= isolated_hit_flag_d;
         parity_zero_q <= parity_zero_d;
         cache_swap_q <= cache_swap_d;
         dcache_isolate_q <= dcache_isolate_d;
         irq_mask_q <= irq_mask_d;
         tlb_seen_q <= 1'b1;
         flip_eff_q <= flip_eff_d;
         // a build without translation reports shutdown from the first edge
         tlb_shutdown_q <= tlb_shutdown_d | (!HAS_TLB && !tlb_seen_q);
      end
   end

   // cause and answer flops
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         delay_slot_flag_q <= 1'b0;
         coproc_err_q <= 2'b00;
         soft_irq_q <= 2'b00;
         exception_kind_q <= EXC_INTERRUPT;
         hw_pending_q <= 6'h00;
         return_point_q <= 32'h0000_0000;
         cop_unusable_q <= 1'b0;
         cop_unit_q <= 2'b00;
         addr_violation_q <= 1'b0;
         take_irq_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         delay_slot_flag_q <= delay_slot_flag_d;
         coproc_err_q <= coproc_err_d;
         soft_irq_q <= soft_irq_d;
         exception_kind_q <= exception_kind_d;
         hw_pending_q <= irq_pins;
         return_point_q <= return_point_d;
         cop_unusable_q <= cop_unusable_d;
         cop_unit_q <= cop_unit_d;
         addr_violation_q <= addr_violation_d;
         take_irq_q <= take_irq_d;
         rdata_q <= rdata_d;
      end
   end

   // outputs straight from flops
   assign creg_rdata = rdata_q;
   assign cop_unusable = cop_unusable_q;
   assign cop_unusable_unit = cop_unit_q;
   assign addr_violation = addr_violation_q;
   assign take_irq = take_irq_q;
   assign kernel_now = stack_q[1];
   // flip applies only while running with user privilege; registered with the
   // next privilege bit so it never lags a push or pop by a cycle
   assign user_endian_flip_eff = flip_eff_q;
   assign boot_vector_select = boot_vector_q;
   assign parity_zero_mode = parity_zero_q;
   assign dcache_isolate = dcache_isolate_q;
   assign cache_swap = cache_swap_q;
   assign tlb_shutdown = tlb_shutdown_q;
   assign return_point_reg = return_point_q;

endmodule // cpu_exception_status

// ---- rtl/cpu_exc_pkg.sv ----
// package for the processor mode/exception state block
// assumes a single clock domain and a pipeline that presents one event per cycle
package cpu_exc_pkg;

   // register numbers in the control register space
   localparam logic [4:0] REG_MODE_STATUS = 5'h0c;
   localparam logic [4:0] REG_CAUSE = 5'h0d;
   localparam logic [4:0] REG_RETURN_POINT = 5'h0e;

   // status field positions
   localparam int ST_CU_HI = 31;
   localparam int ST_CU_LO = 28;
   localparam int ST_RE = 25;
   localparam int ST_BEV = 22;
   localparam int ST_TS = 21;
   localparam int ST_PE = 20;
   localparam int ST_CM = 19;
   localparam int ST_PZ = 18;
   localparam int ST_SWC = 17;
   localparam int ST_ISC = 16;
   localparam int ST_IM_HI = 15;
   localparam int ST_IM_LO = 8;

   // cause field positions
   localparam int CA_BD = 31;
   localparam int CA_CE_HI = 29;
   localparam int CA_CE_LO = 28;
   localparam int CA_IP_HI = 15;
   localparam int CA_IP_LO = 8;
   localparam int CA_SW_HI = 9;
   localparam int CA_EXC_HI = 6;
   localparam int CA_EXC_LO = 2;

   // reset values
   localparam logic [3:0] CU_RESET = 4'h0;
   localparam logic BEV_RESET = 1'b1;
   localparam logic [7:0] IM_RESET = 8'h00;
   localparam logic [5:0] KU_IE_RESET = 6'h02; // kernel, interrupts off

   // user address ceiling: user may reach 0x0000_0000..0x7fff_ffff
   localparam logic [31:0] USER_ADDR_MAX = 32'h7fff_ffff;

   // exception kind codes
   typedef enum logic [4:0] {
      EXC_INTERRUPT = 5'h00,
      EXC_TLB_MOD = 5'h01,
      EXC_TLB_READ_MISS = 5'h02,
      EXC_TLB_WRITE_MISS = 5'h03,
      EXC_LOAD_ALIGN = 5'h04,
      EXC_STORE_ALIGN = 5'h05,
      EXC_FETCH_BUS = 5'h06,
      EXC_LOAD_BUS = 5'h07,
      EXC_SYSCALL = 5'h08,
      EXC_BREAKPOINT = 5'h09,
      EXC_RESERVED_INSN = 5'h0a,
      EXC_COPROC_UNUSABLE = 5'h0b,
      EXC_OVERFLOW = 5'h0c
   } exception_kind_t;

   // one exception report from the pipeline
   typedef struct packed {
      logic valid;
      exception_kind_t kind;
      logic [31:0] pc;
      logic in_delay_slot;
   } exc_req_t;

   // one coprocessor instruction being issued
   typedef struct packed {
      logic valid;
      logic [1:0] unit;
   } cop_req_t;

   // control register write/read access
   typedef struct packed {
      logic wr;
      logic [4:0] num;
      logic [31:0] data;
   } creg_acc_t;

   // cache side events
   typedef struct packed {
      logic parity_err;
      logic isolated_load;
      logic isolated_hit;
      logic tlb_multi_hit;
   } cache_evt_t;

   // three-deep privilege/enable stack: {old, prev, now}, each {kernel, irq_on}
   typedef enum logic [1:0] {
      STK_HOLD = 2'b00,
      STK_PUSH = 2'b01,
      STK_POP = 2'b10,
      STK_WRITE = 2'b11
   } stack_op_t;

endpackage

// ---- rtl/mode_stack.sv ----
// kernel/interrupt-enable stack, three entries of two bits
// assumes push, pop and write arrive as one decoded operation per cycle
`timescale 1ns/1ps
module mode_stack
   import cpu_exc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input stack_op_t op,
   input wire logic [5:0] wr_data,
   // state
   output logic [5:0] stack_q
);

   logic [5:0] stack_d;

   // next stack value
   always_comb begin
      stack_d = stack_q;
      case (op)
         STK_PUSH: stack_d = {stack_q[3:0], 2'b10};
         STK_POP: stack_d = {stack_q[5:4], stack_q[5:2]};
         STK_WRITE: stack_d = wr_data;
         default: stack_d = stack_q;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stack_q <= KU_IE_RESET;
      end else begin
         stack_q <= stack_d;
      end
   end

endmodule // mode_stack

// ---- bench/cpu_exception_status_sva.sv ----
// checker for the mode/exception state block
// sees only the top module ports; one clock domain
`timescale 1ns/1ps
module cpu_exception_status_sva
   import cpu_exc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // requests
   input exc_req_t exc,
   input cop_req_t cop,
   input wire logic [31:0] fetch_addr,
   input wire logic user_access_valid,
   input cache_evt_t cache_evt,
   // responses
   input wire logic [1:0] cop_unusable_unit,
   input wire logic addr_violation,
   input wire logic take_irq,
   input wire logic kernel_now,
   input wire logic tlb_shutdown,
   input wire logic [31:0] return_point_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // stack push forces kernel mode, interrupts off for two cycles
   exc_kernel_a: assert property (exc.valid |=> kernel_now)
      else $error("kernel mode not entered");
   irq_held_off_a: assert property (exc.valid |=> (!take_irq)[*2])
      else $error("irq taken right after exception");
   // restart point moves back to the branch
   delay_point_a: assert property (exc.valid && exc.in_delay_slot |=> return_point_reg == $past(exc.pc) - 32'h4)
      else $error("delay slot return point wrong");
   cop_unit_a: assert property (cop.valid |=> cop_unusable_unit == $past(cop.unit))
      else $error("coprocessor number not kept");
   // user address ceiling, both sides of the boundary
   user_high_a: assert property (user_access_valid && !kernel_now && fetch_addr > USER_ADDR_MAX |=> addr_violation)
      else $error("high user address allowed");
   user_low_a: assert property (user_access_valid && fetch_addr <= USER_ADDR_MAX |=> !addr_violation)
      else $error("low user address refused");
   // shutdown is sticky until reset
   shutdown_hold_a: assert property (tlb_shutdown |=> tlb_shutdown)
      else $error("shutdown cleared without reset");
   shutdown_set_a: assert property (cache_evt.tlb_multi_hit |=> tlb_shutdown)
      else $error("shutdown not set on multi hit");
endmodule // cpu_exception_status_sva

bind cpu_exception_status cpu_exception_status_sva chk (.clk, .reset, .exc, .cop, .fetch_addr, .user_access_valid,
   .cache_evt, .cop_unusable_unit, .addr_violation, .take_irq, .kernel_now, .tlb_shutdown, .return_point_reg);

// ---- bench/irq_source.sv ----
// model of the external interrupt devices
// assumes the bench asks for levels; lines change only on clk edges
`timescale 1ns/1ps
module irq_source (
   // clock
   input wire logic clk,
   // levels asked for by the bench
   input wire logic [5:0] want,
   // level lines toward the block
   output logic [5:0] irq_pins
);
   // devices hold a level until serviced, so no pulses here
   always_ff @(posedge clk) begin
      irq_pins <= want;
   end
endmodule // irq_source

// ---- bench/cpu_exception_status_tb.sv ----
// self-checking bench for the mode/exception state block
// assumes the irq_source model drives the interrupt pins
`timescale 1ns/1ps
module cpu_exception_status_tb;
   import cpu_exc_pkg::*;
   logic clk, reset, restore_exc, user_access_valid, cop_unusable, addr_violation, take_irq, kernel_now;
   logic user_endian_flip_eff, boot_vector_select, parity_zero_mode, dcache_isolate, cache_swap, tlb_shutdown;
   logic [1:0] cop_unusable_unit;
   logic bare_shutdown;
   logic [5:0] want, irq_pins;
   logic [31:0] fetch_addr, creg_rdata, return_point_reg, rd;
   creg_acc_t creg;
   exc_req_t exc;
   cop_req_t cop;
   cache_evt_t cache_evt;
   int n_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   cpu_exception_status dut (.clk, .reset, .irq_pins, .creg, .creg_rdata, .exc, .restore_exc, .cop, .fetch_addr,
      .user_access_valid, .cache_evt, .cop_unusable, .cop_unusable_unit, .addr_violation, .take_irq, .kernel_now,
      .user_endian_flip_eff, .boot_vector_select, .parity_zero_mode, .dcache_isolate, .cache_swap, .tlb_shutdown,
      .return_point_reg);
   irq_source model (.clk, .want, .irq_pins);
   // build without translation hardware; only its shutdown flag is watched
   cpu_exception_status #(.HAS_TLB(1'b0)) dut_bare (.clk, .reset, .irq_pins, .creg, .creg_rdata(), .exc,
      .restore_exc, .cop, .fetch_addr, .user_access_valid, .cache_evt, .cop_unusable(), .cop_unusable_unit(),
      .addr_violation(), .take_irq(), .kernel_now(), .user_endian_flip_eff(), .boot_vector_select(),
      .parity_zero_mode(), .dcache_isolate(), .cache_swap(), .tlb_shutdown(bare_shutdown), .return_point_reg());

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // hang guard, well above the few hundred cycles needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // register write: held over one sampling edge
   task automatic wr(input logic [4:0] n, input logic [31:0] d);
      @(posedge clk);
      creg <= '{1'b1, n, d};
      @(posedge clk);
      creg.wr <= 1'b0;
   endtask

   // register read: data lands one cycle after the number
   task automatic rd_reg(input logic [4:0] n);
      @(posedge clk);
      creg.num <= n;
      @(posedge clk);
      #1 rd = creg_rdata;
   endtask

   task automatic cop_try(input logic [1:0] u, input logic exp);
      @(posedge clk);
      cop <= '{1'b1, u};
      @(posedge clk);
      cop.valid <= 1'b0;
      #1 chk("cop unusable", exp, cop_unusable);
   endtask

   task automatic addr_try(input logic [31:0] a, input logic exp);
      @(posedge clk);
      fetch_addr <= a;
      user_access_valid <= 1'b1;
      @(posedge clk);
      user_access_valid <= 1'b0;
      #1 chk("addr violation", exp, addr_violation);
   endtask

   task automatic evt(input cache_evt_t e);
      @(posedge clk);
      cache_evt <= e;
      @(posedge clk);
      cache_evt <= '0;
   endtask

   task automatic t_reset();
      rd_reg(REG_MODE_STATUS);
      chk("status reset", 32'h0040_0002, rd);
      chk("kernel reset", 32'h1, kernel_now);
      chk("no tlb at reset", 32'h1, bare_shutdown);
      $display("test reset done");
   endtask

   task automatic t_modes();
      wr(REG_MODE_STATUS, 32'hf207_ff01);
      rd_reg(REG_MODE_STATUS);
      chk("status rw", 32'hf207_ff01, rd);
      chk("mode bits", 32'h2e, {user_endian_flip_eff, boot_vector_select, parity_zero_mode, cache_swap,
         dcache_isolate, kernel_now});
      wr(REG_MODE_STATUS, 32'h0200_0002);
      #1 chk("endian in kernel", 32'h0, user_endian_flip_eff);
      $display("test modes done");
   endtask

   task automatic t_cop();
      wr(REG_MODE_STATUS, 32'h0);
      for (int u = 0; u < 4; u++) cop_try(u[1:0], 1'b1);
      addr_try(32'h7fff_ffff, 1'b0);
      addr_try(32'h8000_0000, 1'b1);
      wr(REG_MODE_STATUS, 32'hf000_0000);
      for (int u = 0; u < 4; u++) cop_try(u[1:0], 1'b0);
      wr(REG_MODE_STATUS, 32'h2);
      for (int u = 0; u < 4; u++) cop_try(u[1:0], u != 0);
      $display("test coprocessor done");
   endtask

   // each source alone, then masked, then globally off
   task automatic t_irq();
      for (int i = 0; i < 8; i++) begin
         wr(REG_MODE_STATUS, (32'h100 << i) | 32'h1);
         if (i < 2) wr(REG_CAUSE, 32'h100 << i);
         else want <= 6'h1 << (i - 2);
         repeat (4) @(posedge clk);
         rd_reg(REG_CAUSE);
         chk("pending", 32'h100 << i, rd);
         chk("irq taken", 32'h1, take_irq);
         wr(REG_MODE_STATUS, ~(32'h100 << i) & 32'hff01);
         repeat (3) @(posedge clk);
         #1 chk("irq masked", 32'h0, take_irq);
         wr(REG_MODE_STATUS, 32'hff00);
         repeat (3) @(posedge clk);
         #1 chk("irq disabled", 32'h0, take_irq);
         wr(REG_CAUSE, 32'h0);
         want <= 6'h0;
      end
      $display("test interrupts done");
   endtask

   // codes 0 to 11 except 10, odd ones in a delay slot, then restore
   task automatic t_exc();
      logic [31:0] pc, m;
      for (int k = 0; k < 12; k++) begin
         if (k == 10) continue;
         pc = 32'h100 + 32'(k) * 4;
         m = (k == 11) ? 32'hffff_ffff : 32'hcfff_ffff;
         wr(REG_MODE_STATUS, 32'h1);
         cop_try(2'h2, 1'b1);
         @(posedge clk);
         exc <= '{1'b1, exception_kind_t'(k[4:0]), pc, k[0]};
         @(posedge clk);
         exc.valid <= 1'b0;
         #1 chk("return point", pc - (k[0] ? 32'h4 : 32'h0), return_point_reg);
         rd_reg(REG_MODE_STATUS);
         chk("stack push", 32'h6, rd);
         rd_reg(REG_CAUSE);
         chk("cause", {k[0], 1'b0, 2'h2, 21'h0, k[4:0], 2'h0} & m, rd & m);
         @(posedge clk);
         restore_exc <= 1'b1;
         @(posedge clk);
         restore_exc <= 1'b0;
         rd_reg(REG_MODE_STATUS);
         chk("stack pop", 32'h1, rd);
      end
      $display("test exceptions done");
   endtask

   task automatic t_cache();
      wr(REG_MODE_STATUS, 32'h0001_0002);
      evt('{1'b1, 1'b1, 1'b1, 1'b0});
      rd_reg(REG_MODE_STATUS);
      chk("parity and hit", 32'h0019_0002, rd);
      chk("no trap", 32'h0, take_irq);
      evt('{1'b0, 1'b1, 1'b0, 1'b0});
      rd_reg(REG_MODE_STATUS);
      chk("isolated miss", 32'h0, rd[19]);
      wr(REG_MODE_STATUS, 32'h0004_0002);
      evt('{1'b1, 1'b0, 1'b0, 1'b0});
      rd_reg(REG_MODE_STATUS);
      chk("parity unchecked", 32'h0004_0002, rd);
      chk("parity zero mode", 32'h1, parity_zero_mode);
      evt('{1'b0, 1'b0, 1'b0, 1'b1});
      #1 chk("shutdown set", 32'h1, tlb_shutdown);
      wr(REG_MODE_STATUS, 32'h2);
      #1 chk("shutdown kept", 32'h1, tlb_shutdown);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1 chk("shutdown cleared", 32'h0, tlb_shutdown);
      chk("no tlb after reset", 32'h1, bare_shutdown);
      $display("test cache done");
   endtask

   initial begin
      reset = 1'b1;
      want = 6'h0;
      creg = '0;
      exc = '0;
      cop = '0;
      cache_evt = '0;
      restore_exc = 1'b0;
      user_access_valid = 1'b0;
      fetch_addr = 32'h0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_modes();
      t_cop();
      t_irq();
      t_exc();
      t_cache();
      summarize();
   end
endmodule // cpu_exception_status_tb
